// ### verilog/cds_clock_control.sv
// Main clock conditioning and low-power memory chip-select timing.
// Assumes an APB master on ref_clk and a slow 32 kHz clock on slowClkIn.
// Behaviour
// - Doubler code zero bypasses the doubler; oscillator clock passes undoubled.
// - Codes one to fifteen give low time of 6 to 20 ns.
// - Doubled clock is oscillator xor its delayed inverted copy.
// - Only write strobes and early output enable launch on the falling edge; the code registers all strobes on the rising edge.
// - Zero-wait memory access spans two adjacent processor clocks.
// - Spreader changes low phase by up to 3 ns or 4.5 ns.
// - Short chip select only when dividing by 4, 6 or 8, per control bit.
// - Short chip select asserts only for the final two oscillator clocks.
// - Zero-wait read lasts two processor clocks; each wait adds one.
// - Short mode drops chip select on stack write right after I/O.
// - Self-timed select starts at last clock and holds for a programmed time.
// - Self-timed mode latches read data at end of timed interval.
// - Self-timed select relies only on its own delay element; the code counts its width in ref_clk cycles.
// - The 32 kHz clock may be divided further down to 2 kHz.
// - Clock select field picks processor clock source and divisor.
// - Self-timed field: zero disables, codes four to seven pick widths.
// - Slow divider field: zero disables, codes four to seven divide 2 to 16.
`timescale 1ns/100ps
`default_nettype none

module cds_clock_control
    import cds_pkg::*;
(
    // Clock and reset
    input  wire logic          ref_clk,
    input  wire logic          rst,
    // APB slave
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output logic               pready,
    output logic               pslverr,
    output logic [31:0]        prdata,
    // Slow clock pin
    input  wire logic          slowClkIn,
    // Memory cycle request
    input  wire cds_mem_req_t  memReq,
    output logic               memBusy,
    output logic               memDone,
    output logic               dataLatch,
    // Memory strobes
    output logic               memCsN,
    output logic               memOeN,
    output logic               memWeN,
    // Clock status
    output logic               cpuTick,
    output logic               mainOscOn,
    output logic               doublerBypass,
    output logic [4:0]         doublerLowNs,
    output logic [12:0]        spreadPs
);

    // ==========================================================
    // Decoders
    function automatic logic [3:0] fastDiv(input logic [2:0] sel);
        case (sel)
            CSEL_OSC:  fastDiv = 4'h1;
            CSEL_OSC2: fastDiv = 4'h2;
            CSEL_OSC4: fastDiv = 4'h4;
            CSEL_OSC6: fastDiv = 4'h6;
            default:   fastDiv = 4'h8;
        endcase
    endfunction

    function automatic logic [4:0] slowDiv(input logic [2:0] code);
        case (code)
            3'h4:    slowDiv = 5'h02;
            3'h5:    slowDiv = 5'h04;
            3'h6:    slowDiv = 5'h08;
            3'h7:    slowDiv = 5'h10;
            default: slowDiv = 5'h01;
        endcase
    endfunction

    function automatic logic [2:0] selfCyc(input logic [2:0] code);
        case (code)
            3'h4:    selfCyc = ST_CYC_4;
            3'h5:    selfCyc = ST_CYC_5;
            3'h6:    selfCyc = ST_CYC_6;
            default: selfCyc = ST_CYC_7;
        endcase
    endfunction

    cds_state_t s;
    cds_state_t n;
    logic       slowSel;
    logic       shortMode;
    logic       selfMode;
    logic [3:0] fd;
    logic [4:0] sd;

    // ==========================================================
    // Mode decode
    // source select
    assign slowSel = (s.clkSel == CSEL_SLOW) || (s.clkSel == CSEL_SLOWX);
    assign shortMode = s.pscShort && (s.clkSel == CSEL_OSC8A || s.clkSel == CSEL_OSC8B
                       || s.clkSel == CSEL_OSC4 || s.clkSel == CSEL_OSC6);
    assign selfMode = slowSel && s.pscSelf[2];
    assign fd = fastDiv(s.clkSel);
    assign sd = slowDiv(s.pscDiv);

    // ==========================================================
    // Next state
    always_comb begin
        logic tick;
        logic slowEdge;
        logic csOn;
        logic divWr;
        tick     = 1'b0;
        divWr    = 1'b0;
        slowEdge = s.slowSync[1] & ~s.slowPrev;
        csOn     = 1'b0;
        n        = s;
        n.pready  = 1'b0;
        n.pslverr = 1'b0;
        n.prdata  = 32'h0000_0000;
        n.done    = 1'b0;
        n.latch   = 1'b0;

        // Register access, answered in the second access cycle
        if (psel && penable && !s.pready) begin
            n.pready = 1'b1;
            if (paddr[1:0] != 2'h0) begin
                n.pslverr = 1'b1;
            end else begin
                case (paddr[7:2])
                    IDX_GCS: begin
                        n.prdata[CSEL_LSB +: 3] = s.clkSel;
                        if (pwrite) n.clkSel = pwdata[CSEL_LSB +: 3];
                    end
                    IDX_PSC: begin
                        n.prdata[PSC_ST_LSB +: 3] = s.pscSelf;
                        n.prdata[PSC_SHORT]       = s.pscShort;
                        n.prdata[PSC_DV_LSB +: 3] = s.pscDiv;
                        if (pwrite) begin
                            n.pscSelf  = pwdata[PSC_ST_LSB +: 3];
                            n.pscShort = pwdata[PSC_SHORT];
                            n.pscDiv   = pwdata[PSC_DV_LSB +: 3];
                            divWr      = 1'b1;
                        end
                    end
                    IDX_DBL: begin
                        n.prdata[DBL_LSB +: 4] = s.dblCode;
                        if (pwrite) n.dblCode = pwdata[DBL_LSB +: 4];
                    end
                    IDX_SPR: begin
                        n.prdata[SPR_LSB +: 2] = s.spread;
                        if (pwrite) n.spread = pwdata[SPR_LSB +: 2];
                    end
                    default: n.pslverr = 1'b1;
                endcase
            end
        end

        // Processor clock: fast divider or divided slow clock
        n.slowSync = {s.slowSync[0], slowClkIn};
        n.slowPrev = s.slowSync[1];
        if (slowSel) begin
            n.fastCnt = 4'h0;
            if (slowEdge) begin
                if ({1'b0, s.slowCnt} >= sd - 5'h01) begin
                    n.slowCnt = 4'h0;
                    tick      = 1'b1;
                end else begin
                    n.slowCnt = s.slowCnt + 4'h1;
                end
            end
        end else begin
            n.slowCnt = 4'h0;
            if (s.fastCnt >= fd - 4'h1) begin
                n.fastCnt = 4'h0;
                tick      = 1'b1;
            end else begin
                n.fastCnt = s.fastCnt + 4'h1;
            end
        end
        if (divWr) n.slowCnt = 4'h0;
        n.cpuTick = tick;

        // self-timed width counted by its own timer
        if (s.timer != 3'h0) begin
            n.timer = s.timer - 3'h1;
            if (s.timer == 3'h1 && !s.write) n.latch = 1'b1;
        end

        // cycle of two clocks plus waits
        if (!s.busy && memReq.start) begin
            n.busy  = 1'b1;
            n.rem   = 3'h2 + {1'b0, memReq.waits};
            n.write = memReq.write;
            // stack write after I/O loses select
            n.noCs  = memReq.afterIo && shortMode;
        end else if (s.busy && tick) begin
            if (s.rem == 3'h1) begin
                n.busy = 1'b0;
                n.done = 1'b1;
                n.noCs = 1'b0;
                if (!selfMode && !s.write) n.latch = 1'b1;
            end else begin
                n.rem = s.rem - 3'h1;
                if (s.rem == 3'h2 && selfMode) n.timer = selfCyc(s.pscSelf);
            end
        end

        // short select only in final two oscillator clocks
        if (shortMode) begin
            csOn = n.busy && n.rem == 3'h1 && n.fastCnt >= fd - 4'h2 && !n.noCs;
        end else if (selfMode) begin
            csOn = n.timer != 3'h0;
        end else begin
            csOn = n.busy;
        end
        // strobes share the rising-edge flop; write delay is at the pad
        n.csN = !csOn;
        n.oeN = !(csOn && !n.write);
        n.weN = !(csOn && n.write);

        n.dblBypass = (s.dblCode == 4'h0);
        n.dblLowNs = n.dblBypass ? 5'h00 : {1'b0, s.dblCode} + DBL_BASE_NS;
        case (s.spread)
            2'h0:       n.spreadPs = 13'h0000;
            SPR_NORMAL: n.spreadPs = SPR_NORMAL_PS;
            default:    n.spreadPs = SPR_STRONG_PS;
        endcase
        n.oscOn = (s.clkSel != CSEL_SLOWX);
    end

    // ==========================================================
    // State register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s           <= '0;
            s.clkSel    <= RST_CSEL;
            s.dblCode   <= RST_DBL;
            s.csN       <= 1'b1;
            s.oeN       <= 1'b1;
            s.weN       <= 1'b1;
            s.dblBypass <= 1'b1;
            s.oscOn     <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign pready        = s.pready;
    assign pslverr       = s.pslverr;
    assign prdata        = s.prdata;
    assign memBusy       = s.busy;
    assign memDone       = s.done;
    assign dataLatch     = s.latch;
    assign memCsN        = s.csN;
    assign memOeN        = s.oeN;
    assign memWeN        = s.weN;
    assign cpuTick       = s.cpuTick;
    assign mainOscOn     = s.oscOn;
    assign doublerBypass = s.dblBypass;
    assign doublerLowNs  = s.dblLowNs;
    assign spreadPs      = s.spreadPs;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    AST_BYPASS: assert property (s.dblCode == 4'h0 |=> doublerBypass)
        else $error("doubler not bypassed at code zero");
    AST_LOWTIME: assert property (s.dblCode != 4'h0 |=>
        doublerLowNs == {1'b0, $past(s.dblCode)} + DBL_BASE_NS)
        else $error("doubler low time wrong");
    AST_SPREAD: assert property (s.spread == SPR_NORMAL |=> spreadPs == SPR_NORMAL_PS)
        else $error("normal spread limit wrong");
    AST_SHORT_TWO: assert property (shortMode && $stable(s.clkSel) && $fell(memCsN)
        |-> !memCsN ##1 !memCsN ##1 memCsN)
        else $error("short select not two clocks");
    AST_ZW_OSC6: assert property (!s.busy && memReq.start && memReq.waits == 2'h0
        && s.clkSel == CSEL_OSC6 ##1 s.clkSel == CSEL_OSC6 [*6]
        |-> ##[1:7] memDone)
        else $error("osc/6 zero-wait cycle too long");
    AST_SELF_W7: assert property (selfMode && s.pscSelf == 3'h7 && $fell(memCsN)
        |-> !memCsN ##1 !memCsN ##1 memCsN)
        else $error("self-timed width wrong");
    AST_SELF_LATCH: assert property (selfMode && $rose(memCsN) && !$past(s.write)
        |-> dataLatch)
        else $error("self-timed read not latched early");
    AST_SUPPRESS: assert property (s.busy && s.noCs |-> memCsN)
        else $error("select asserted on suppressed write");
    AST_NORMAL_CS: assert property (!shortMode && !selfMode && $stable(s.clkSel)
        && $stable(s.pscShort) && $stable(s.pscSelf) && s.busy |-> !memCsN)
        else $error("normal select missing in cycle");
    AST_OSC_TICK: assert property (s.clkSel == CSEL_OSC && $past(s.clkSel) == CSEL_OSC
        |=> cpuTick)
        else $error("undivided clock not ticking every cycle");
    AST_SLOW_DIV: assert property (slowSel |-> {1'b0, s.slowCnt} < sd)
        else $error("slow divider count out of range");
    AST_RST_DBL: assert property ($past(rst) |-> s.dblCode == 4'h0)
        else $error("doubler code not zero after reset");

    COV_SHORT: cover property (shortMode && $fell(memCsN));
    COV_SELF: cover property (selfMode && dataLatch);
    COV_WAIT: cover property (memDone && $past(s.rem) == 3'h1 && s.clkSel == CSEL_OSC2);

endmodule // cds_clock_control

`default_nettype wire

// ### verilog/cds_pkg.sv
// Constants, register map and state layout for the clock conditioning block.
// Assumes a 10 MHz reference clock and a 32-bit APB register bus.
package cds_pkg;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int ST_NS_4 = 296;
    localparam int ST_NS_5 = 234;
    localparam int ST_NS_6 = 171;
    localparam int ST_NS_7 = 109;
    localparam logic [2:0] ST_CYC_4 = 3'((ST_NS_4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [2:0] ST_CYC_5 = 3'((ST_NS_5 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [2:0] ST_CYC_6 = 3'((ST_NS_6 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [2:0] ST_CYC_7 = 3'((ST_NS_7 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ==========================================================
    // Register indices (byte address is four times the index)
    localparam logic [5:0] IDX_GCS = 6'h00;
    localparam logic [5:0] IDX_PSC = 6'h0D;
    localparam logic [5:0] IDX_DBL = 6'h0F;
    localparam logic [5:0] IDX_SPR = 6'h10;

    // ==========================================================
    // Field positions
    localparam int CSEL_LSB  = 2;
    localparam int PSC_ST_LSB = 5;
    localparam int PSC_SHORT = 4;
    localparam int PSC_DV_LSB = 0;
    localparam int DBL_LSB   = 0;
    localparam int SPR_LSB   = 0;

    // ==========================================================
    // Codes and reset values
    localparam logic [2:0] CSEL_OSC8A = 3'h0;
    localparam logic [2:0] CSEL_OSC8B = 3'h1;
    localparam logic [2:0] CSEL_OSC   = 3'h2;
    localparam logic [2:0] CSEL_OSC2  = 3'h3;
    localparam logic [2:0] CSEL_SLOW  = 3'h4;
    localparam logic [2:0] CSEL_SLOWX = 3'h5;
    localparam logic [2:0] CSEL_OSC4  = 3'h6;
    localparam logic [2:0] CSEL_OSC6  = 3'h7;
    localparam logic [2:0] RST_CSEL   = CSEL_OSC8A;
    localparam logic [3:0] RST_DBL    = 4'h0;
    localparam logic [4:0] DBL_BASE_NS = 5'h05;
    localparam logic [1:0] SPR_NORMAL = 2'h1;
    localparam logic [12:0] SPR_NORMAL_PS = 13'd3000;
    localparam logic [12:0] SPR_STRONG_PS = 13'd4500;

    // ==========================================================
    // Types
    typedef struct packed {
        logic       start;
        logic [1:0] waits;
        logic       write;
        logic       afterIo;
    } cds_mem_req_t;

    typedef struct packed {
        logic [3:0]  dblCode;
        logic [2:0]  clkSel;
        logic [2:0]  pscSelf;
        logic        pscShort;
        logic [2:0]  pscDiv;
        logic [1:0]  spread;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic [1:0]  slowSync;
        logic        slowPrev;
        logic [3:0]  fastCnt;
        logic [3:0]  slowCnt;
        logic        cpuTick;
        logic        busy;
        logic [2:0]  rem;
        logic        write;
        logic        noCs;
        logic [2:0]  timer;
        logic        csN;
        logic        oeN;
        logic        weN;
        logic        latch;
        logic        done;
        logic        dblBypass;
        logic [4:0]  dblLowNs;
        logic [12:0] spreadPs;
        logic        oscOn;
    } cds_state_t;

endpackage

// ### test/cds_mem_model.sv
// Memory chip model on the strobe side of the clock control block.
// Assumes strobes change only at rising edges of ref_clk.
`timescale 1ns/100ps
`default_nettype none

module cds_mem_model (
    // Clock
    input  wire logic ref_clk,
    // Strobes
    input  wire logic memCsN,
    input  wire logic memOeN,
    input  wire logic memWeN,
    // Observations
    output int        csWidth,
    output int        csCount,
    output logic      strobeFault
);
    int run;

    initial begin
        run = 0;
        csWidth = 0;
        csCount = 0;
        strobeFault = 1'b0;
    end

    // ==========================================================
    // Chip select width and strobe qualification
    always @(posedge ref_clk) begin
        if (memCsN === 1'b0) begin
            run <= run + 1;
        end else if (run != 0) begin
            csWidth <= run;
            csCount <= csCount + 1;
            run <= 0;
        end
        if (memCsN !== 1'b0 && (memOeN === 1'b0 || memWeN === 1'b0)) begin
            strobeFault <= 1'b1;
        end
    end
endmodule // cds_mem_model

`default_nettype wire

// ### test/tb_top.sv
// Self-checking bench for the clock conditioning block.
// Assumes the design package and a 10 MHz reference clock.
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    import cds_pkg::*;

    logic         ref_clk, rst, psel, penable, pwrite, slowClkIn;
    logic [7:0]   paddr;
    logic [31:0]  pwdata, prdata;
    logic         pready, pslverr, memBusy, memDone, dataLatch;
    logic         memCsN, memOeN, memWeN, cpuTick, mainOscOn, doublerBypass;
    logic [4:0]   doublerLowNs;
    logic [12:0]  spreadPs;
    cds_mem_req_t memReq;
    int           csWidth, csCount, err_count, checked;
    logic         strobeFault;

    cds_clock_control dut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .slowClkIn(slowClkIn), .memReq(memReq), .memBusy(memBusy),
        .memDone(memDone), .dataLatch(dataLatch), .memCsN(memCsN), .memOeN(memOeN),
        .memWeN(memWeN), .cpuTick(cpuTick), .mainOscOn(mainOscOn),
        .doublerBypass(doublerBypass), .doublerLowNs(doublerLowNs), .spreadPs(spreadPs));

    cds_mem_model mem (.ref_clk(ref_clk), .memCsN(memCsN), .memOeN(memOeN),
        .memWeN(memWeN), .csWidth(csWidth), .csCount(csCount), .strobeFault(strobeFault));

    // ==========================================================
    // Clocks and watchdog
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    initial begin
        slowClkIn = 1'b0;
        forever #15258.8 slowClkIn = ~slowClkIn;
    end
    initial begin
        #5000000;
        err_count++;
        close_out();
    end

    // ==========================================================
    // Shared tasks
    task automatic close_out;
        $display("counts: checked %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int t;
        t = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            t++;
        end while (pready !== 1'b1 && t < 20);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (t >= 20) err_count++;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
        chk("write error", 32'h0, 32'(e));
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk($sformatf("reg %0h", a), x, r);
    endtask

    task automatic wait_tick(output int n);
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (cpuTick !== 1'b1 && n < 6000);
        if (n >= 6000) err_count++;
    endtask

    task automatic mem_run(input logic [1:0] w, input logic io, output int nb,
                           output int lat, output int rise);
        int   t;
        logic pc;
        t = 0;
        nb = 0;
        lat = -1;
        rise = -2;
        pc = 1'b1;
        wait_tick(t);
        memReq <= '{1'b1, w, 1'b0, io};
        @(posedge ref_clk);
        memReq.start <= 1'b0;
        t = 0;
        while (memDone !== 1'b1 && t < 20000) begin
            @(posedge ref_clk);
            t++;
            if (memBusy === 1'b1) nb++;
            if (dataLatch === 1'b1) lat = t;
            if (pc === 1'b0 && memCsN === 1'b1) rise = t;
            pc = memCsN;
        end
        if (t >= 20000) err_count++;
        repeat (2) @(posedge ref_clk);
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset;
        rdchk(8'h00, 32'h0);
        rdchk(8'h34, 32'h0);
        rdchk(8'h3C, 32'h0);
        chk("bypass", 32'h1, 32'(doublerBypass));
        chk("low time", 32'h0, 32'(doublerLowNs));
        chk("spread", 32'h0, 32'(spreadPs));
        $display("test reset done");
    endtask

    task automatic t_regs;
        logic [31:0] r;
        logic        e;
        for (int c = 0; c < 4; c++) begin
            wr(8'h40, 32'(c));
            rdchk(8'h40, 32'(c));
            chk("spread", (c == 0) ? 32'h0 : (c == 1) ? 32'd3000 : 32'd4500, 32'(spreadPs));
        end
        for (int c = 0; c < 16; c++) begin
            wr(8'h3C, 32'h0000_00F0 | 32'(c));
            rdchk(8'h3C, 32'(c));
            chk("low time", (c == 0) ? 32'h0 : 32'(c + 5), 32'(doublerLowNs));
            chk("bypass", 32'(c == 0), 32'(doublerBypass));
        end
        apb(1'b0, 8'h08, 32'h0, r, e);
        chk("unmapped error", 32'h1, 32'(e));
        chk("unmapped data", 32'h0, r);
        apb(1'b1, 8'h3D, 32'h5, r, e);
        chk("misaligned error", 32'h1, 32'(e));
        rdchk(8'h3C, 32'hF);
        $display("test registers done");
    endtask

    task automatic t_clk;
        int n;
        int e;
        for (int s = 0; s < 8; s++) begin
            wr(8'h00, 32'(s << 2));
            wait_tick(n);
            wait_tick(n);
            e = (s < 2) ? 8 : (s == 2) ? 1 : (s == 3) ? 2 : (s == 6) ? 4 : (s == 7) ? 6 : 305;
            chk("tick period", 32'h1, 32'(n >= e - e / 75 && n <= e + e / 75));
            chk("osc on", 32'(s != 5), 32'(mainOscOn));
        end
        wr(8'h00, 32'h10);
        for (int d = 4; d < 8; d++) begin
            wr(8'h34, 32'(d));
            wait_tick(n);
            wait_tick(n);
            e = 305 * (2 << (d - 4));
            chk("slow period", 32'h1, 32'(n >= e - 6 && n <= e + 8));
        end
        wr(8'h34, 32'h0);
        $display("test clock select done");
    endtask

    task automatic t_mem;
        int a;
        int b;
        int l;
        int r;
        int k;
        wr(8'h00, 32'h8);
        mem_run(2'h0, 1'b0, a, l, r);
        chk("busy undivided", 32'd2, 32'(a));
        chk("cs undivided", 32'd2, 32'(csWidth));
        wr(8'h34, 32'h10);
        mem_run(2'h1, 1'b0, a, l, r);
        chk("cs short undivided", 32'(a), 32'(csWidth));
        wr(8'h00, 32'h1C);
        wr(8'h34, 32'h0);
        mem_run(2'h0, 1'b0, a, l, r);
        mem_run(2'h1, 1'b0, b, l, r);
        chk("wait length", 32'd6, 32'(b - a));
        chk("cs normal", 32'(b), 32'(csWidth));
        wr(8'h34, 32'h10);
        mem_run(2'h1, 1'b0, a, l, r);
        chk("cs short", 32'd2, 32'(csWidth));
        chk("busy short", 32'(b), 32'(a));
        k = csCount;
        mem_run(2'h0, 1'b1, a, l, r);
        chk("cs suppressed", 32'(k), 32'(csCount));
        chk("strobe outside cs", 32'h0, 32'(strobeFault));
        $display("test memory cycle done");
    endtask

    task automatic t_self;
        int a;
        int l;
        int r;
        wr(8'h00, 32'h10);
        for (int c = 4; c < 8; c++) begin
            wr(8'h34, 32'(c << 5));
            mem_run(2'h0, 1'b0, a, l, r);
            chk("self cs width", (c < 6) ? 32'd3 : 32'd2, 32'(csWidth));
            chk("latch at cs end", 32'(r), 32'(l));
        end
        wr(8'h00, 32'h14);
        mem_run(2'h0, 1'b0, a, l, r);
        chk("self cs osc off", 32'd2, 32'(csWidth));
        $display("test self timed done");
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        memReq = '0;
        err_count = 0;
        checked = 0;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset();
        t_regs();
        t_clk();
        t_mem();
        t_self();
        close_out();
    end
endmodule // tb_top

`default_nettype wire
